// ===== rtl/lp_dram_pkg.sv
package lp_dram_pkg;
	// command pins packed as {chip select, row, column, write} strobes
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_LOAD = 4'h0;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_DEEP = 4'h6;
	// bank select values choosing the configuration target
	localparam logic [1:0] BA_BASE = 2'h0;
	localparam logic [1:0] BA_EXT = 2'h2;
	// base configuration fields
	localparam int LAT_LSB = 4;
	localparam int LAT_MSB = 6;
	localparam int BTYPE_BIT = 3;
	localparam int BLEN_LSB = 0;
	localparam int BLEN_MSB = 2;
	// extended configuration fields
	localparam int DRV_LSB = 5;
	localparam int DRV_MSB = 6;
	localparam int PARTIAL_ARRAY_REFRESH_SEL_LSB = 0;
	localparam int PARTIAL_ARRAY_REFRESH_SEL_MSB = 2;
	localparam logic [12:0] CFG_RESET = 13'h0000;
	// burst length codes
	localparam logic [2:0] BLEN_2 = 3'h1;
	localparam logic [2:0] BLEN_16 = 3'h4;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int PD_EXIT_CYCLES = 1;
	localparam int SR_EXIT_CYCLES = 2;
	localparam int REFRESH_INTERVAL_NS = 7800;
	localparam int REFRESH_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int REFRESH_HOT_CYCLES = REFRESH_CYCLES / 2;
	localparam int ROW_COUNT = 8192;
	localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SEL_MAX_SHIFT = 3'h4;

	typedef enum logic [2:0] {
		st_idle,
		st_pd_pending,
		st_powerdown,
		st_pd_exit,
		st_self_refresh,
		st_sr_exit,
		st_deep_sleep
	} power_state_e;
endpackage : lp_dram_pkg

// ===== rtl/burst_order_gen.sv
`timescale 1ns/1ps
module burst_order_gen (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic start_in,
	input wire logic [3:0] start_col_in,
	input wire logic interleave_in,
	input wire logic [2:0] len_code_in,
	output logic [3:0] col_out,
	output logic active_out
);
	logic [3:0] beat_ff;
	logic [3:0] base_ff;
	logic [3:0] mask_ff;
	logic type_ff;
	logic [3:0] nxt_mask;
	logic [3:0] nxt_beat;

	// out-of-range length codes fall back to the shortest burst
	always_comb begin
		if (len_code_in >= lp_dram_pkg::BLEN_2 &&
			len_code_in <= lp_dram_pkg::BLEN_16) begin
			nxt_mask = 4'((5'h01 << len_code_in) - 5'h01);
		end else begin
			nxt_mask = 4'h1;
		end
		nxt_beat = beat_ff + 4'h1;
	end

	function automatic logic [3:0] order(input logic [3:0] base,
		input logic [3:0] beat, input logic [3:0] mask, input logic ilv);
		if (ilv) begin
			order = base ^ beat;
		end else begin
			order = (base & ~mask) | ((base + beat) & mask);
		end
	endfunction : order

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			active_out <= 1'b0;
			beat_ff <= 4'h0;
			base_ff <= 4'h0;
			mask_ff <= 4'h1;
			type_ff <= 1'b0;
			col_out <= 4'h0;
		end else if (start_in) begin
			active_out <= 1'b1;
			beat_ff <= 4'h0;
			base_ff <= start_col_in;
			mask_ff <= nxt_mask;
			type_ff <= interleave_in;
			col_out <= start_col_in;
		end else if (active_out) begin
			if (beat_ff == mask_ff) begin
				active_out <= 1'b0;
			end else begin
				beat_ff <= nxt_beat;
				col_out <= order(base_ff, nxt_beat, mask_ff, type_ff);
			end
		end
	end

	property p_burst_end;
		@(posedge clk_sys_in) disable iff (srst_in)
		active_out && beat_ff == mask_ff && !start_in |=> !active_out;
	endproperty
	a_burst_end: assert property (p_burst_end)
		else $error("burst did not release the data bus");

	property p_first_beat;
		@(posedge clk_sys_in) disable iff (srst_in)
		start_in |=> active_out && col_out == $past(start_col_in);
	endproperty
	a_first_beat: assert property (p_first_beat)
		else $error("first beat is not the starting column");

	property p_seq_step;
		@(posedge clk_sys_in) disable iff (srst_in)
		active_out && !start_in && !type_ff && beat_ff != mask_ff |=>
			(col_out & mask_ff) == (($past(col_out) + 4'h1) & mask_ff);
	endproperty
	a_seq_step: assert property (p_seq_step)
		else $error("sequential burst skipped a column");

	property p_ilv_step;
		@(posedge clk_sys_in) disable iff (srst_in)
		active_out && !start_in && type_ff && beat_ff != mask_ff |=>
			col_out == (base_ff ^ beat_ff);
	endproperty
	a_ilv_step: assert property (p_ilv_step)
		else $error("interleave burst out of order");
endmodule : burst_order_gen

// ===== rtl/lp_dram_init_mode_power.sv
// Overview of operation
// - self-refresh keeps refreshing while clock enable low; idle after exit delay.
// - power-down entered after entry delay, held while enable low, no refresh.
// - power-down starts second edge after enable falls, first edge being no-op.
// - last command activate gives active power-down, precharge gives precharge one.
// - one cycle enable low then high does not enter power-down.
// - power-down exit takes at least one cycle after exit command.
// - banks idle before deep sleep (entry does not check for an open row); deep sleep held while enable low.
// - configuration taken from A0 to A12, bank select chooses register.
// - base register: latency A6-A4, burst type A3, length A2-A0.
// - burst length 2, 4, 8 or 16; data bus released after burst.
// - burst order sequential modulo length or interleave by exclusive-or.
// - extended register: drive strength A6-A5, partial refresh A2-A0.
// - self-refresh covers only the selected partial array.
// - self-refresh rate follows on-die temperature sensor, not a register.
`timescale 1ns/1ps
module lp_dram_init_mode_power (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic cke_in,
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [12:0] addr_in,
	input wire logic [1:0] ba_in,
	input wire logic temp_hot_in,
	output logic idle_out,
	output logic powerdown_out,
	output logic active_pd_out,
	output logic self_refresh_out,
	output logic deep_sleep_out,
	output logic init_done_out,
	output logic [2:0] column_access_latency_out,
	output logic burst_order_type_out,
	output logic [2:0] burst_word_count_out,
	output logic [1:0] drive_strength_out,
	output logic [2:0] partial_array_refresh_sel_out,
	output logic refresh_tick_out,
	output logic [12:0] refresh_row_out,
	output logic [3:0] burst_col_out,
	output logic dq_oe_out
);
	lp_dram_pkg::power_state_e state_ff, nxt_state;
	logic cke_prev_ff, act_open_ff, base_loaded_ff, ext_loaded_ff;
	logic [3:0] exit_cnt_ff, cmd;
	logic [12:0] burst_latency_config_ff, drive_refresh_config_ff;
	logic [9:0] tick_cnt_ff, tick_limit;
	logic is_nop, cke_fall, cmd_ok, load_base, load_ext, read_start;
	logic [13:0] row_span;
	logic [2:0] partial_array_refresh_sel_shift;

	assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
	assign is_nop = cs_n_in || cmd == lp_dram_pkg::CMD_NOP;
	assign cke_fall = cke_prev_ff && !cke_in;
	// commands count only with the enable high on both edges
	assign cmd_ok = cke_prev_ff && cke_in && !cs_n_in &&
		state_ff == lp_dram_pkg::st_idle;
	assign load_base = cmd_ok && cmd == lp_dram_pkg::CMD_LOAD &&
		ba_in == lp_dram_pkg::BA_BASE;
	assign load_ext = cmd_ok && cmd == lp_dram_pkg::CMD_LOAD &&
		ba_in == lp_dram_pkg::BA_EXT;
	assign read_start = cmd_ok && cmd == lp_dram_pkg::CMD_READ;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			lp_dram_pkg::st_idle: begin
				if (cke_fall) begin
					if (!cs_n_in && cmd == lp_dram_pkg::CMD_REF) begin
						nxt_state = lp_dram_pkg::st_self_refresh;
					end else if (!cs_n_in && cmd == lp_dram_pkg::CMD_DEEP) begin
						nxt_state = lp_dram_pkg::st_deep_sleep;
					end else if (is_nop) begin
						nxt_state = lp_dram_pkg::st_pd_pending;
					end
				end
			end
			lp_dram_pkg::st_pd_pending: begin
				// a single low cycle is not enough to enter power-down
				if (cke_in) begin
					nxt_state = lp_dram_pkg::st_idle;
				end else begin
					nxt_state = lp_dram_pkg::st_powerdown;
				end
			end
			lp_dram_pkg::st_powerdown: begin
				if (cke_in) begin
					nxt_state = lp_dram_pkg::st_pd_exit;
				end
			end
			lp_dram_pkg::st_pd_exit, lp_dram_pkg::st_sr_exit: begin
				if (exit_cnt_ff == 4'h0) begin
					nxt_state = lp_dram_pkg::st_idle;
				end
			end
			lp_dram_pkg::st_self_refresh: begin
				if (cke_in) begin
					nxt_state = lp_dram_pkg::st_sr_exit;
				end
			end
			lp_dram_pkg::st_deep_sleep: begin
				if (cke_in) begin
					nxt_state = lp_dram_pkg::st_idle;
				end
			end
			default: nxt_state = lp_dram_pkg::st_idle;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			state_ff <= lp_dram_pkg::st_idle;
			cke_prev_ff <= 1'b0;
			idle_out <= 1'b1;
			powerdown_out <= 1'b0;
			self_refresh_out <= 1'b0;
			deep_sleep_out <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cke_prev_ff <= cke_in;
			idle_out <= nxt_state == lp_dram_pkg::st_idle;
			powerdown_out <= nxt_state == lp_dram_pkg::st_powerdown;
			self_refresh_out <= nxt_state == lp_dram_pkg::st_self_refresh;
			deep_sleep_out <= nxt_state == lp_dram_pkg::st_deep_sleep;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			exit_cnt_ff <= 4'h0;
		end else if (state_ff == lp_dram_pkg::st_powerdown && cke_in) begin
			exit_cnt_ff <= 4'(lp_dram_pkg::PD_EXIT_CYCLES - 1);
		end else if (state_ff == lp_dram_pkg::st_self_refresh && cke_in) begin
			exit_cnt_ff <= 4'(lp_dram_pkg::SR_EXIT_CYCLES - 1);
		end else if (exit_cnt_ff != 4'h0) begin
			exit_cnt_ff <= exit_cnt_ff - 4'h1;
		end
	end

	// open row remembered so power-down knows which flavour it is
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			act_open_ff <= 1'b0;
			active_pd_out <= 1'b0;
		end else begin
			if (cmd_ok && cmd == lp_dram_pkg::CMD_ACT) begin
				act_open_ff <= 1'b1;
			end else if (cmd_ok && cmd == lp_dram_pkg::CMD_PRE) begin
				act_open_ff <= 1'b0;
			end
			active_pd_out <= nxt_state == lp_dram_pkg::st_powerdown &&
				act_open_ff;
		end
	end

	// deep sleep loses configuration; software must reload both
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || state_ff == lp_dram_pkg::st_deep_sleep) begin
			burst_latency_config_ff <= lp_dram_pkg::CFG_RESET;
			drive_refresh_config_ff <= lp_dram_pkg::CFG_RESET;
			base_loaded_ff <= 1'b0;
			ext_loaded_ff <= 1'b0;
			init_done_out <= 1'b0;
		end else begin
			if (load_base) begin
				burst_latency_config_ff <= addr_in;
				base_loaded_ff <= 1'b1;
			end
			if (load_ext) begin
				drive_refresh_config_ff <= addr_in;
				ext_loaded_ff <= 1'b1;
			end
			init_done_out <= (base_loaded_ff || load_base) &&
				(ext_loaded_ff || load_ext);
		end
	end

	assign column_access_latency_out =
		burst_latency_config_ff[lp_dram_pkg::LAT_MSB:lp_dram_pkg::LAT_LSB];
	assign burst_order_type_out =
		burst_latency_config_ff[lp_dram_pkg::BTYPE_BIT];
	assign burst_word_count_out =
		burst_latency_config_ff[lp_dram_pkg::BLEN_MSB:lp_dram_pkg::BLEN_LSB];
	assign drive_strength_out =
		drive_refresh_config_ff[lp_dram_pkg::DRV_MSB:lp_dram_pkg::DRV_LSB];
	assign partial_array_refresh_sel_out =
		drive_refresh_config_ff[lp_dram_pkg::PARTIAL_ARRAY_REFRESH_SEL_MSB:lp_dram_pkg::PARTIAL_ARRAY_REFRESH_SEL_LSB];

	// hot die refreshes twice as often; no register is involved
	always_comb begin
		if (temp_hot_in) begin
			tick_limit = 10'(lp_dram_pkg::REFRESH_HOT_CYCLES - 1);
		end else begin
			tick_limit = 10'(lp_dram_pkg::REFRESH_CYCLES - 1);
		end
		if (partial_array_refresh_sel_out > lp_dram_pkg::PARTIAL_ARRAY_REFRESH_SEL_MAX_SHIFT) begin
			partial_array_refresh_sel_shift = 3'h0;
		end else begin
			partial_array_refresh_sel_shift = partial_array_refresh_sel_out;
		end
		row_span = 14'(lp_dram_pkg::ROW_COUNT) >> partial_array_refresh_sel_shift;
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in || state_ff != lp_dram_pkg::st_self_refresh) begin
			tick_cnt_ff <= 10'h000;
			refresh_tick_out <= 1'b0;
			refresh_row_out <= 13'h0000;
		end else if (tick_cnt_ff >= tick_limit) begin
			tick_cnt_ff <= 10'h000;
			refresh_tick_out <= 1'b1;
			if (14'(refresh_row_out) + 14'h0001 >= row_span) begin
				refresh_row_out <= 13'h0000;
			end else begin
				refresh_row_out <= refresh_row_out + 13'h0001;
			end
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 10'h001;
			refresh_tick_out <= 1'b0;
		end
	end

	burst_order_gen u_burst (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.start_in(read_start),
		.start_col_in(addr_in[3:0]),
		.interleave_in(burst_order_type_out),
		.len_code_in(burst_word_count_out),
		.col_out(burst_col_out),
		.active_out(dq_oe_out)
	);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	sequence s_nop_fall;
		state_ff == lp_dram_pkg::st_idle && cke_fall && is_nop &&
			!(!cs_n_in && (cmd == lp_dram_pkg::CMD_REF ||
			cmd == lp_dram_pkg::CMD_DEEP));
	endsequence
	property p_pd_entry;
		s_nop_fall ##1 !cke_in |=> powerdown_out;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("pd entry");
	property p_pd_glitch;
		s_nop_fall ##1 cke_in |=> !powerdown_out;
	endproperty
	a_pd_glitch: assert property (p_pd_glitch) else $error("pd glitch");
	property p_pd_hold;
		powerdown_out && !cke_in |=> powerdown_out && !refresh_tick_out;
	endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("pd hold");
	property p_pd_exit;
		powerdown_out && cke_in |=> !powerdown_out && !idle_out ##1 idle_out;
	endproperty
	a_pd_exit: assert property (p_pd_exit) else $error("pd exit");
	property p_sr_hold;
		self_refresh_out && !cke_in |=> self_refresh_out;
	endproperty
	a_sr_hold: assert property (p_sr_hold) else $error("sr hold");
	property p_sr_exit;
		self_refresh_out && cke_in |=> !idle_out ##1 !idle_out ##1 idle_out;
	endproperty
	a_sr_exit: assert property (p_sr_exit) else $error("sr exit");
	property p_deep_hold;
		deep_sleep_out && !cke_in |=> deep_sleep_out;
	endproperty
	a_deep_hold: assert property (p_deep_hold) else $error("deep hold");
	property p_active_pd;
		$rose(powerdown_out) |-> active_pd_out == $past(act_open_ff);
	endproperty
	a_active_pd: assert property (p_active_pd) else $error("pd kind");
	property p_base_load;
		load_base |=> burst_word_count_out == $past(addr_in[2:0]) &&
			column_access_latency_out == $past(addr_in[6:4]);
	endproperty
	a_base_load: assert property (p_base_load) else $error("base load");
	property p_ext_load;
		load_ext |=> drive_strength_out == $past(addr_in[6:5]) &&
			partial_array_refresh_sel_out == $past(addr_in[2:0]);
	endproperty
	a_ext_load: assert property (p_ext_load) else $error("ext load");
	property p_row_span;
		self_refresh_out |-> 14'(refresh_row_out) < row_span;
	endproperty
	a_row_span: assert property (p_row_span) else $error("row span");
endmodule : lp_dram_init_mode_power

// ===== test/mem_ctrl_model.sv
`timescale 1ns/1ps
module mem_ctrl_model #(
	parameter int POWERUP_CYCLES = 10000,
	parameter int PRECHARGE_WAIT = 3,
	parameter int REFRESH_WAIT = 8
) (
	input wire logic clk_sys_in,
	output logic cke_out,
	output logic cs_n_out,
	output logic ras_n_out,
	output logic cas_n_out,
	output logic we_n_out,
	output logic [12:0] addr_out,
	output logic [1:0] ba_out
);
	initial begin
		cke_out = 1'b1;
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} = lp_dram_pkg::CMD_NOP;
		addr_out = 13'h0000;
		ba_out = 2'h0;
	end

	task automatic step(input logic [3:0] cmd, input logic [12:0] a,
			input logic [1:0] b, input logic ck);
		cke_out = ck;
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} = cmd;
		addr_out = a;
		ba_out = b;
		@(posedge clk_sys_in);
		#1;
		// released pins never keep showing the old value
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} = {1'b1, ~cmd[2:0]};
		addr_out = ~a;
		ba_out = ~b;
	endtask : step

	task automatic hold(input int n, input logic ck);
		cke_out = ck;
		repeat (n) begin
			@(posedge clk_sys_in);
			#1;
		end
	endtask : hold

	// also serves as the deep sleep exit sequence
	task automatic init_seq(input logic [12:0] base, input logic [12:0] ext);
		hold(POWERUP_CYCLES, 1'b1);
		step(lp_dram_pkg::CMD_PRE, 13'h0400, 2'h0, 1'b1);
		hold(PRECHARGE_WAIT, 1'b1);
		repeat (2) begin
			step(lp_dram_pkg::CMD_REF, 13'h0000, 2'h0, 1'b1);
			hold(REFRESH_WAIT, 1'b1);
		end
		step(lp_dram_pkg::CMD_LOAD, base, lp_dram_pkg::BA_BASE, 1'b1);
		hold(2, 1'b1);
		step(lp_dram_pkg::CMD_LOAD, ext, lp_dram_pkg::BA_EXT, 1'b1);
		hold(2, 1'b1);
	endtask : init_seq

	task automatic self_entry();
		step(lp_dram_pkg::CMD_REF, 13'h0000, 2'h0, 1'b0);
	endtask : self_entry

	task automatic deep_entry();
		step(lp_dram_pkg::CMD_DEEP, 13'h0000, 2'h0, 1'b0);
	endtask : deep_entry
endmodule : mem_ctrl_model

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic temp_hot_in = 1'b0;
	logic cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in;
	logic [12:0] addr_in;
	logic [1:0] ba_in;
	logic idle_out, powerdown_out, active_pd_out, self_refresh_out;
	logic deep_sleep_out, init_done_out, burst_order_type_out;
	logic refresh_tick_out, dq_oe_out;
	logic [2:0] column_access_latency_out, burst_word_count_out;
	logic [2:0] partial_array_refresh_sel_out;
	logic [1:0] drive_strength_out;
	logic [12:0] refresh_row_out;
	logic [3:0] burst_col_out;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int ticks = 0;
	int m_bt, m_bl, m_drv, m_partial_array_refresh_sel;
	logic [3:0] exp_q[$];

	always #10 clk_sys_in = ~clk_sys_in;

	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (refresh_tick_out === 1'b1) begin
			ticks <= ticks + 1;
		end
	end

	mem_ctrl_model u_ctrl (
		.clk_sys_in,
		.cke_out(cke_in), .cs_n_out(cs_n_in), .ras_n_out(ras_n_in),
		.cas_n_out(cas_n_in), .we_n_out(we_n_in), .addr_out(addr_in),
		.ba_out(ba_in)
	);

	lp_dram_init_mode_power u_dut (
		.clk_sys_in, .srst_in, .cke_in, .cs_n_in, .ras_n_in, .cas_n_in,
		.we_n_in, .addr_in, .ba_in, .temp_hot_in, .idle_out,
		.powerdown_out, .active_pd_out, .self_refresh_out,
		.deep_sleep_out, .init_done_out, .column_access_latency_out,
		.burst_order_type_out, .burst_word_count_out,
		.drive_strength_out, .partial_array_refresh_sel_out,
		.refresh_tick_out, .refresh_row_out, .burst_col_out, .dq_oe_out
	);

	task automatic check(input string what, input logic [12:0] exp,
			input logic [12:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	function automatic logic [12:0] base_val();
		return 13'((3 << 4) | (m_bt << 3) | m_bl);
	endfunction : base_val

	function automatic logic [12:0] ext_val();
		return 13'((m_drv << 5) | m_partial_array_refresh_sel);
	endfunction : ext_val

	function automatic logic [3:0] beat_col(int st, int len, int i);
		if (m_bt == 1) begin
			return 4'(st ^ i);
		end
		return 4'((st & ~(len - 1)) | ((st + i) & (len - 1)));
	endfunction : beat_col

	task automatic rand_cfg();
		m_bt = $urandom_range(1, 0);
		m_bl = $urandom_range(4, 1);
		m_drv = $urandom_range(3, 0);
		m_partial_array_refresh_sel = $urandom_range(7, 0);
	endtask : rand_cfg

	task automatic check_cfg();
		check("latency", 13'h0003, column_access_latency_out);
		check("burst type", 13'(m_bt), burst_order_type_out);
		check("burst length", 13'(m_bl), burst_word_count_out);
		check("drive", 13'(m_drv), drive_strength_out);
		check("partial", 13'(m_partial_array_refresh_sel), partial_array_refresh_sel_out);
	endtask : check_cfg

	// a pulse seen on entry is skipped so back-to-back calls see new ones
	task automatic wait_tick(output int at, output logic [12:0] row);
		int n;
		n = 0;
		do begin
			u_ctrl.hold(1, 1'b0);
			n++;
		end while (refresh_tick_out !== 1'b1 && n < 1000);
		check("tick", 13'h0001, refresh_tick_out);
		at = cyc;
		row = refresh_row_out;
	endtask : wait_tick

	initial begin
		#(60000 * 20);
		err_count++;
		$display("watchdog expired");
		end_sim();
	end

	initial begin
		int t1, t2, rows, len, st, n;
		logic [12:0] r1, r2;
		void'($urandom(70));
		repeat (3) @(posedge clk_sys_in);
		#1;
		srst_in = 1'b0;
		check("idle after reset", 13'h0001, idle_out);
		rand_cfg();
		u_ctrl.init_seq(base_val(), ext_val());
		check("init done", 13'h0001, init_done_out);
		check_cfg();
		u_ctrl.step(lp_dram_pkg::CMD_LOAD, 13'h1fff, 2'h1, 1'b1);
		u_ctrl.hold(2, 1'b1);
		check_cfg();
		$display("test init done");

		for (int code = 1; code <= 4; code++) begin
			for (int bt = 0; bt < 2; bt++) begin
				m_bl = code;
				m_bt = bt;
				u_ctrl.step(lp_dram_pkg::CMD_LOAD, base_val(), 2'h0, 1'b1);
				u_ctrl.hold(2, 1'b1);
				check_cfg();
				len = 2 << (code - 1);
				st = (code == 2 && bt == 1) ? 1 : $urandom_range(15, 0);
				for (int i = 0; i < len; i++) begin
					exp_q.push_back(beat_col(st, len, i));
				end
				u_ctrl.step(lp_dram_pkg::CMD_READ, 13'(st), 2'h0, 1'b1);
				for (int i = 0; i < len; i++) begin
					check("beat", exp_q.pop_front(), burst_col_out);
					check("bus drive", 13'h0001, dq_oe_out);
					u_ctrl.hold(1, 1'b1);
				end
				check("bus released", 13'h0000, dq_oe_out);
			end
		end
		$display("test burst done");

		for (int ap = 0; ap < 2; ap++) begin
			u_ctrl.step(ap ? lp_dram_pkg::CMD_ACT : lp_dram_pkg::CMD_PRE,
				13'h0010, 2'h0, 1'b1);
			// one edge between commands so the pins change once per step
			u_ctrl.hold(1, 1'b1);
			u_ctrl.step(lp_dram_pkg::CMD_NOP, 13'h0000, 2'h0, 1'b0);
			check("early powerdown", 13'h0000, powerdown_out);
			u_ctrl.hold(1, 1'b0);
			check("powerdown", 13'h0001, powerdown_out);
			check("active pd", 13'(ap), active_pd_out);
			t1 = ticks;
			u_ctrl.hold(400, 1'b0);
			check("pd ticks", 13'(t1), 13'(ticks));
			check("pd held", 13'h0001, powerdown_out);
			u_ctrl.hold(1, 1'b1);
			check("pd exit", 13'h0000, powerdown_out);
			u_ctrl.hold(1, 1'b1);
			check("idle after pd", 13'h0001, idle_out);
		end
		u_ctrl.step(lp_dram_pkg::CMD_NOP, 13'h0000, 2'h0, 1'b0);
		u_ctrl.hold(1, 1'b1);
		check("short low", 13'h0000, powerdown_out);
		u_ctrl.hold(1, 1'b1);
		check("short low idle", 13'h0001, idle_out);
		$display("test powerdown done");

		// the power-down test left a row open; close it before entry
		u_ctrl.step(lp_dram_pkg::CMD_PRE, 13'h0400, 2'h0, 1'b1);
		u_ctrl.hold(1, 1'b1);
		u_ctrl.self_entry();
		check("self refresh", 13'h0001, self_refresh_out);
		rows = (m_partial_array_refresh_sel > 4) ? lp_dram_pkg::ROW_COUNT
			: (lp_dram_pkg::ROW_COUNT >> m_partial_array_refresh_sel);
		wait_tick(t1, r1);
		wait_tick(t2, r2);
		check("gap", 13'(lp_dram_pkg::REFRESH_CYCLES), 13'(t2 - t1));
		check("row", 13'((r1 + 1) % rows), r2);
		temp_hot_in = 1'b1;
		wait_tick(t1, r1);
		wait_tick(t1, r1);
		wait_tick(t2, r2);
		check("hot gap", 13'(lp_dram_pkg::REFRESH_HOT_CYCLES),
			13'(t2 - t1));
		temp_hot_in = 1'b0;
		u_ctrl.hold(1, 1'b1);
		check("self exit", 13'h0000, self_refresh_out);
		n = 0;
		while (idle_out !== 1'b1 && n < 8) begin
			u_ctrl.hold(1, 1'b1);
			n++;
		end
		check("exit delay", 13'(lp_dram_pkg::SR_EXIT_CYCLES), 13'(n));
		$display("test self refresh done");

		u_ctrl.deep_entry();
		check("deep", 13'h0001, deep_sleep_out);
		u_ctrl.hold(50, 1'b0);
		check("deep held", 13'h0001, deep_sleep_out);
		u_ctrl.hold(1, 1'b1);
		check("deep exit", 13'h0000, deep_sleep_out);
		check("idle after deep", 13'h0001, idle_out);
		check("init cleared", 13'h0000, init_done_out);
		rand_cfg();
		u_ctrl.init_seq(base_val(), ext_val());
		check("reinit done", 13'h0001, init_done_out);
		check_cfg();
		$display("test deep sleep done");
		end_sim();
	end
endmodule : testbench
